// ### rtl/csp_defs.svh
// Constants of the charger supervisory block: register map, fields, timing.
// Assumes a 20 MHz system clock and an 8-bit register port.
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// Clock and times, in ns
`define CSP_CLK_NS 50
`define CSP_INT_PULSE_NS 256000
`define CSP_BLINK_HALF_NS 500000000
`define CSP_HICCUP_OFF_NS 1000000

// Register addresses
`define CSP_A_CTRL0 8'h10
`define CSP_A_CTRL1 8'h11
`define CSP_A_DPDM 8'h12
`define CSP_A_STAT 8'h13
`define CSP_A_CHG 8'h14
`define CSP_A_FLAG0 8'h22
`define CSP_A_FLAG6 8'h4d
`define CSP_A_MASK0 8'h28
`define CSP_A_MASK6 8'h4e
`define CSP_A_RES0 8'h30

// Control 0 fields
`define CSP_C0_STAT_DIS 0
`define CSP_C0_ROLE_EN 1
`define CSP_C0_SRC_EN 2
`define CSP_C0_PIN_SRC 3
`define CSP_C0_HIZ 4
`define CSP_C0_OCP_EN 5
`define CSP_C0_SRC_RETRY_DIS 6
`define CSP_C0_SYS_RETRY_DIS 7
`define CSP_CTRL0_RST 8'h20

// Control 1 fields
`define CSP_C1_SEAM_LO 0
`define CSP_C1_SEAM_HI 1
`define CSP_C1_CONV_EN 2
`define CSP_C1_ONESHOT 3
`define CSP_C1_FET_DIS 4
`define CSP_C1_IN1_FET_EN 5
`define CSP_C1_IBAT_OUT_EN 6
`define CSP_CTRL1_RST 8'h20

// Event bits, group 0
`define CSP_EV_BUS_OV 0
`define CSP_EV_SRC_OV 1
`define CSP_EV_IN1_OV 2
`define CSP_EV_OCP 3
`define CSP_EV_SRC_UV 4
`define CSP_EV_SYS_UV 5
`define CSP_EV_SYS_OV 6
// Event bits, group 1
`define CSP_EV_CONV_DONE 0
`define CSP_EV_DET_DONE 1
`define CSP_EV_ROLE_SWAP 2
`define CSP_EV_SEAMLESS 3
// Event bits, group 6
`define CSP_EV_CHG_CHANGE 0

`define CSP_MASK_LOW_RST 8'h00
`define CSP_MASK_HIGH_RST 8'hff
`define CSP_RETRY_MAX 3'h7
`define CSP_LAST_CH 4'ha
`define CSP_I_IN_CH 4'h0
`define CSP_I_BAT_CH 4'h1
`define CSP_NO_MANUAL 3'h0

`endif

// ### rtl/csp_pkg.sv
// Types of the charger supervisory block.
// Used with csp_defs.svh; nothing here is imported.
package csp_pkg;

   typedef enum logic [2:0] {
      CHG_IDLE = 3'b000, CHG_TRICKLE = 3'b001, CHG_PRE = 3'b010, CHG_FAST = 3'b011,
      CHG_IEOC = 3'b100, CHG_BACKGROUND = 3'b101, CHG_DONE = 3'b110
   } csp_chg_t;

   typedef enum logic [1:0] {HIC_RUN = 2'b00, HIC_OFF = 2'b01, HIC_DONE = 2'b10} csp_hic_t;
   typedef enum logic {ADC_IDLE = 1'b0, ADC_WAIT = 1'b1} csp_adc_t;

   // Analog comparator and charger core levels
   typedef struct packed {
      logic bus_above_uvlo;
      logic bus_ovp;
      logic die_hot;
      logic detect_done;
      logic bc12_busy;
      logic bus_below_mivr;
      logic adapter_present;
      logic src_ovp;
      logic in1_ovp;
      logic ibus_oc;
      logic src_uv;
      logic sys_uv;
      logic sys_ovp;
      logic fault_stop;
      logic term_disable;
   } csp_cmp_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] dpdm;
      logic [6:0][7:0] flag;
      logic [6:0][7:0] mask;
      logic [10:0][15:0] res;
      logic [7:0] rdata;
      logic bus_ov, src_ov, in1_ov, sys_ov, src_mode, pg, stat_oe, blink, det_prev, adapt_prev;
      logic [2:0] chg_prev;
      logic [12:0] int_cnt;
      logic [28:0] blink_cnt;
      csp_hic_t src_st;
      csp_hic_t sys_st;
      logic [2:0] src_retry;
      logic [2:0] sys_retry;
      logic [15:0] hic_cnt_src;
      logic [15:0] hic_cnt_sys;
      csp_adc_t adc_st;
      logic [3:0] adc_ch;
      logic [2:0] dp, dm;
   } csp_state_t;

endpackage

// ### rtl/csp_top.sv
// Supervisory logic of a buck-boost charger: power-good and status pins,
// interrupt pulse and event flags, role swap, converter sequencing, protections.
// Assumes all inputs synchronous to clk and a strobe-driven 8-bit register port.
`timescale 1ns/1ns
`include "csp_defs.svh"

module csp_top #(
   parameter int INT_CYC = (`CSP_INT_PULSE_NS + `CSP_CLK_NS - 1) / `CSP_CLK_NS,
   parameter int BLINK_CYC = `CSP_BLINK_HALF_NS / `CSP_CLK_NS,
   parameter int HIC_CYC = `CSP_HICCUP_OFF_NS / `CSP_CLK_NS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Comparators and charger core
   input wire csp_pkg::csp_cmp_t cmp,
   input wire logic [2:0] charge_state,
   // Converter sample port
   output logic adc_req,
   output logic [3:0] adc_channel,
   input wire logic adc_done,
   input wire logic [15:0] adc_data,
   // Open-drain and shared pins
   output logic power_good_pin_o,
   output logic power_good_pin_oe,
   output logic int_pin_o,
   output logic int_pin_oe,
   input wire logic status_or_role_pin_i,
   output logic status_or_role_pin_o,
   output logic status_or_role_pin_oe,
   // Power stage controls
   output logic switching_enable,
   output logic source_mode_active,
   output logic input_one_fet_drive,
   output logic battery_current_output_enable,
   output logic [2:0] reported_charge_state,
   output logic [2:0] plus_line_level,
   output logic [2:0] minus_line_level
);

   csp_pkg::csp_state_t s;
   csp_pkg::csp_state_t n;
   logic [6:0][7:0] evt;
   logic [6:0] grp_new;
   logic charging;
   logic hiz;
   logic role_mode;

   // Per-group detection of events not yet latched nor masked
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_new
         assign grp_new[gi] = |(evt[gi] & ~s.flag[gi] & ~s.mask[gi]);
      end
   endgenerate

   // Shared decoded levels
   assign charging = (charge_state != csp_pkg::CHG_IDLE);
   assign hiz = s.ctrl0[`CSP_C0_HIZ];
   assign role_mode = s.ctrl0[`CSP_C0_STAT_DIS] & s.ctrl0[`CSP_C0_ROLE_EN];

   // Next-state logic
   always_comb begin
      n = s;
      evt = '0;
      n.rdata = 8'h00;

      // Register writes
      if (reg_wr) begin
         if (reg_addr == `CSP_A_CTRL0) n.ctrl0 = reg_wdata;
         if (reg_addr == `CSP_A_CTRL1) n.ctrl1 = reg_wdata;
         if (reg_addr == `CSP_A_DPDM) n.dpdm = reg_wdata;
         for (int i = 0; i < 6; i++) begin
            if (reg_addr == `CSP_A_MASK0 + 8'(i)) n.mask[i] = reg_wdata;
         end
         if (reg_addr == `CSP_A_MASK6) n.mask[6] = reg_wdata;
      end

      // Register reads; a flag read clears the group
      if (reg_rd) begin
         if (reg_addr == `CSP_A_CTRL0) n.rdata = s.ctrl0;
         if (reg_addr == `CSP_A_CTRL1) n.rdata = s.ctrl1;
         if (reg_addr == `CSP_A_DPDM) n.rdata = s.dpdm;
         if (reg_addr == `CSP_A_STAT) begin
            n.rdata = {2'b00, s.src_mode, s.sys_ov, s.in1_ov, s.src_ov, s.bus_ov, s.pg};
         end
         if (reg_addr == `CSP_A_CHG) n.rdata = {5'h00, reported_charge_state};
         for (int i = 0; i < 6; i++) begin
            if (reg_addr == `CSP_A_FLAG0 + 8'(i)) begin
               n.rdata = s.flag[i];
               n.flag[i] = 8'h00;
            end
            if (reg_addr == `CSP_A_MASK0 + 8'(i)) n.rdata = s.mask[i];
         end
         if (reg_addr == `CSP_A_FLAG6) begin
            n.rdata = s.flag[6];
            n.flag[6] = 8'h00;
         end
         if (reg_addr == `CSP_A_MASK6) n.rdata = s.mask[6];
         for (int i = 0; i < 11; i++) begin
            if (reg_addr == `CSP_A_RES0 + 8'(2 * i)) n.rdata = s.res[i][7:0];
            if (reg_addr == `CSP_A_RES0 + 8'(2 * i + 1)) n.rdata = s.res[i][15:8];
         end
      end

      // Bus overvoltage in charge mode
      n.bus_ov = cmp.bus_ovp & ~s.src_mode;
      evt[0][`CSP_EV_BUS_OV] = n.bus_ov & ~s.bus_ov;
      // Bus overvoltage in source mode
      n.src_ov = cmp.src_ovp & s.src_mode;
      evt[0][`CSP_EV_SRC_OV] = n.src_ov & ~s.src_ov;
      // System overvoltage
      n.sys_ov = cmp.sys_ovp;
      evt[0][`CSP_EV_SYS_OV] = cmp.sys_ovp & ~s.sys_ov;
      // Input one overvoltage drops its fet drive
      n.in1_ov = cmp.in1_ovp;
      if (cmp.in1_ovp) n.ctrl1[`CSP_C1_IN1_FET_EN] = 1'b0;
      evt[0][`CSP_EV_IN1_OV] = cmp.in1_ovp & ~s.in1_ov;
      // Input overcurrent enters high impedance and blocks the fets
      if (s.ctrl0[`CSP_C0_OCP_EN] & cmp.ibus_oc & ~s.src_mode & ~hiz) begin
         n.ctrl0[`CSP_C0_HIZ] = 1'b1;
         n.ctrl1[`CSP_C1_FET_DIS] = 1'b1;
         evt[0][`CSP_EV_OCP] = 1'b1;
      end

      // Source undervoltage hiccup
      unique case (s.src_st)
         csp_pkg::HIC_RUN: begin
            if (!cmp.src_uv) begin
               n.src_retry = 3'h0;
            end else if (s.src_mode && !s.ctrl0[`CSP_C0_SRC_RETRY_DIS]) begin
               if (s.src_retry == `CSP_RETRY_MAX) begin
                  n.src_st = csp_pkg::HIC_DONE;
               end else begin
                  n.src_st = csp_pkg::HIC_OFF;
                  n.hic_cnt_src = 16'(HIC_CYC - 1);
               end
            end
         end
         csp_pkg::HIC_OFF: begin
            if (s.hic_cnt_src == 16'h0000) begin
               n.src_st = csp_pkg::HIC_RUN;
               n.src_retry = s.src_retry + 3'h1;
            end else begin
               n.hic_cnt_src = s.hic_cnt_src - 16'h0001;
            end
         end
         csp_pkg::HIC_DONE: begin
            n.ctrl0[`CSP_C0_SRC_EN] = 1'b0;
            n.src_mode = 1'b0;
            evt[0][`CSP_EV_SRC_UV] = 1'b1;
            n.src_retry = 3'h0;
            n.src_st = csp_pkg::HIC_RUN;
         end
         default: n.src_st = csp_pkg::HIC_RUN;
      endcase

      // System undervoltage hiccup
      unique case (s.sys_st)
         csp_pkg::HIC_RUN: begin
            if (!cmp.sys_uv) begin
               n.sys_retry = 3'h0;
            end else if (!s.ctrl0[`CSP_C0_SYS_RETRY_DIS] && !hiz) begin
               if (s.sys_retry == 3'h0) evt[0][`CSP_EV_SYS_UV] = 1'b1;
               if (s.sys_retry == `CSP_RETRY_MAX) begin
                  n.sys_st = csp_pkg::HIC_DONE;
                  n.ctrl0[`CSP_C0_HIZ] = 1'b1;
               end else begin
                  n.sys_st = csp_pkg::HIC_OFF;
                  n.hic_cnt_sys = 16'(HIC_CYC - 1);
               end
            end
         end
         csp_pkg::HIC_OFF: begin
            if (s.hic_cnt_sys == 16'h0000) begin
               n.sys_st = csp_pkg::HIC_RUN;
               n.sys_retry = s.sys_retry + 3'h1;
            end else begin
               n.hic_cnt_sys = s.hic_cnt_sys - 16'h0001;
            end
         end
         csp_pkg::HIC_DONE: begin
            // Leave on high-impedance clear or adapter re-plug
            if (!n.ctrl0[`CSP_C0_HIZ] || (cmp.adapter_present && !s.adapt_prev)) begin
               n.ctrl0[`CSP_C0_HIZ] = 1'b0;
               n.sys_retry = 3'h0;
               n.sys_st = csp_pkg::HIC_RUN;
            end
         end
         default: n.sys_st = csp_pkg::HIC_RUN;
      endcase

      // Source mode entry: software, fast role swap or seamless
      if (!s.src_mode) begin
         if (role_mode && charging && s.ctrl0[`CSP_C0_SRC_EN] && s.ctrl0[`CSP_C0_PIN_SRC]
               && cmp.bus_below_mivr && status_or_role_pin_i) begin
            n.src_mode = 1'b1;
            evt[1][`CSP_EV_ROLE_SWAP] = 1'b1;
         end else if (s.ctrl1[`CSP_C1_SEAM_HI:`CSP_C1_SEAM_LO] != 2'b00 && charging
               && !cmp.adapter_present && cmp.bus_below_mivr) begin
            n.src_mode = 1'b1;
            n.ctrl0[`CSP_C0_SRC_EN] = 1'b1;
            n.ctrl1[`CSP_C1_SEAM_HI:`CSP_C1_SEAM_LO] = 2'b00;
            evt[1][`CSP_EV_SEAMLESS] = 1'b1;
         end else if (s.ctrl0[`CSP_C0_SRC_EN] && !s.ctrl0[`CSP_C0_PIN_SRC]) begin
            n.src_mode = 1'b1;
         end
      end else if (!n.ctrl0[`CSP_C0_SRC_EN]) begin
         n.src_mode = 1'b0;
      end

      // Converter channel sequencing
      unique case (s.adc_st)
         csp_pkg::ADC_IDLE: begin
            if (s.ctrl1[`CSP_C1_CONV_EN]) n.adc_st = csp_pkg::ADC_WAIT;
         end
         csp_pkg::ADC_WAIT: begin
            if (adc_done) begin
               if ((s.adc_ch == `CSP_I_IN_CH || s.adc_ch == `CSP_I_BAT_CH) && s.src_mode) begin
                  n.res[s.adc_ch] = 16'(-adc_data);
               end else begin
                  n.res[s.adc_ch] = adc_data;
               end
               if (s.adc_ch == `CSP_LAST_CH) begin
                  n.adc_ch = 4'h0;
                  n.adc_st = csp_pkg::ADC_IDLE;
                  if (s.ctrl1[`CSP_C1_ONESHOT]) begin
                     n.ctrl1[`CSP_C1_CONV_EN] = 1'b0;
                     evt[1][`CSP_EV_CONV_DONE] = 1'b1;
                  end
               end else begin
                  n.adc_ch = s.adc_ch + 4'h1;
               end
            end
         end
         default: n.adc_st = csp_pkg::ADC_IDLE;
      endcase

      // Detection-done event and manual line levels
      n.det_prev = cmp.detect_done;
      evt[1][`CSP_EV_DET_DONE] = cmp.detect_done & ~s.det_prev;
      if (cmp.bc12_busy || !s.det_prev) begin
         n.dp = `CSP_NO_MANUAL;
         n.dm = `CSP_NO_MANUAL;
      end else begin
         n.dp = s.dpdm[2:0];
         n.dm = s.dpdm[5:3];
      end

      // Charge state change event
      n.chg_prev = charge_state;
      evt[6][`CSP_EV_CHG_CHANGE] = (charge_state != s.chg_prev);
      n.adapt_prev = cmp.adapter_present;

      // Latch events; a set beats a same-cycle read clear
      for (int i = 0; i < 7; i++) begin
         n.flag[i] = n.flag[i] | evt[i];
      end

      // Interrupt pulse timer
      if (|grp_new) begin
         n.int_cnt = 13'(INT_CYC);
      end else if (s.int_cnt != 13'h0000) begin
         n.int_cnt = s.int_cnt - 13'h0001;
      end

      // Blink divider, toggles every half second
      if (s.blink_cnt == 29'h0000_0000) begin
         n.blink_cnt = 29'(BLINK_CYC - 1);
         n.blink = ~s.blink;
      end else begin
         n.blink_cnt = s.blink_cnt - 29'h0000_0001;
      end

      // Power good
      n.pg = cmp.bus_above_uvlo & ~cmp.bus_ovp & ~hiz & ~cmp.die_hot & cmp.detect_done;

      // Status pin drive
      n.stat_oe = 1'b0;
      if (!s.ctrl0[`CSP_C0_STAT_DIS]) begin
         unique case (charge_state)
            csp_pkg::CHG_TRICKLE, csp_pkg::CHG_PRE, csp_pkg::CHG_FAST: n.stat_oe = 1'b1;
            csp_pkg::CHG_IEOC: n.stat_oe = cmp.term_disable;
            csp_pkg::CHG_IDLE: n.stat_oe = cmp.fault_stop & s.blink;
            default: n.stat_oe = 1'b0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.ctrl0 <= `CSP_CTRL0_RST;
         s.ctrl1 <= `CSP_CTRL1_RST;
         s.mask[5:0] <= {6{`CSP_MASK_LOW_RST}};
         s.mask[6] <= `CSP_MASK_HIGH_RST;
         s.src_st <= csp_pkg::HIC_RUN;
         s.sys_st <= csp_pkg::HIC_RUN;
         s.adc_st <= csp_pkg::ADC_IDLE;
      end else begin
         s <= n;
      end
   end

   // Outputs
   assign reg_rdata = s.rdata;
   assign adc_req = (s.adc_st == csp_pkg::ADC_WAIT);
   assign adc_channel = s.adc_ch;
   assign power_good_pin_o = 1'b0;
   assign power_good_pin_oe = s.pg;
   assign int_pin_o = 1'b0;
   assign int_pin_oe = (s.int_cnt != 13'h0000);
   assign status_or_role_pin_o = 1'b0;
   assign status_or_role_pin_oe = s.stat_oe;
   // Switching stops on bus, source or system overvoltage, hiccup off time or high impedance
   assign switching_enable = ~hiz & ~s.bus_ov & ~s.src_ov & ~s.sys_ov
                             & (s.src_st != csp_pkg::HIC_OFF)
                             & (s.sys_st == csp_pkg::HIC_RUN);
   assign source_mode_active = s.src_mode;
   assign input_one_fet_drive = s.ctrl1[`CSP_C1_IN1_FET_EN] & ~s.ctrl1[`CSP_C1_FET_DIS];
   assign battery_current_output_enable = s.ctrl1[`CSP_C1_IBAT_OUT_EN];
   assign reported_charge_state = s.bus_ov ? 3'h0 : charge_state;
   assign plus_line_level = s.dp;
   assign minus_line_level = s.dm;

endmodule // csp_top

// ### tb/csp_top_assertions.sv
// Checker of the charger supervisory block, bound to its top module.
// Assumes one clock domain and the reduced pulse length of the bench.
`timescale 1ns/1ns
module csp_top_checker #(
   parameter int INT_CYC = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Comparators
   input wire csp_pkg::csp_cmp_t cmp,
   input wire logic [2:0] charge_state,
   // Converter port
   input wire logic adc_req,
   input wire logic [3:0] adc_channel,
   input wire logic adc_done,
   // Pins and controls
   input wire logic power_good_pin_o,
   input wire logic power_good_pin_oe,
   input wire logic int_pin_o,
   input wire logic int_pin_oe,
   input wire logic status_or_role_pin_o,
   input wire logic status_or_role_pin_oe,
   input wire logic switching_enable,
   input wire logic source_mode_active,
   input wire logic [2:0] reported_charge_state,
   input wire logic [2:0] plus_line_level,
   input wire logic [2:0] minus_line_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [15:0] hi_cnt_r;
   // Length of the present interrupt pulse
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hi_cnt_r <= 16'h0000;
      end else begin
         hi_cnt_r <= int_pin_oe ? hi_cnt_r + 16'h0001 : 16'h0000;
      end
   end
   // Steps of a converter sample, and the bad-supply condition
   sequence adc_wait_s;
      adc_req && !adc_done;
   endsequence
   sequence adc_take_s;
      adc_req && adc_done && adc_channel < 4'ha;
   endsequence
   sequence supply_bad_s;
      cmp.bus_ovp || !cmp.bus_above_uvlo || cmp.die_hot || !cmp.detect_done;
   endsequence
   pulse_len_a: assert property ($fell(int_pin_oe) |-> hi_cnt_r == INT_CYC)
      else $error("interrupt pulse length wrong");
   pg_drop_a: assert property (supply_bad_s |=> !power_good_pin_oe)
      else $error("power good held while supply bad");
   stat_high_a: assert property ((charge_state inside {3'h5, 3'h6} && !cmp.fault_stop)
      |=> !status_or_role_pin_oe)
      else $error("status pin low when charging finished");
   line_hold_a: assert property (cmp.bc12_busy |=> plus_line_level == 3'h0
      && minus_line_level == 3'h0)
      else $error("manual line level during detection");
   state_force_a: assert property ((cmp.bus_ovp && !source_mode_active)
      |=> reported_charge_state == 3'h0)
      else $error("charge state not forced on bus overvoltage");
   // Charge-mode bus threshold applies only outside source mode, and vice versa
   ovp_stop_a: assert property (((cmp.bus_ovp && !source_mode_active) || cmp.sys_ovp
      || (cmp.src_ovp && source_mode_active)) |=> !switching_enable)
      else $error("switching during overvoltage");
   adc_hold_a: assert property (adc_wait_s |=> adc_req && $stable(adc_channel))
      else $error("sample request dropped early");
   adc_step_a: assert property (adc_take_s |=> adc_channel == $past(adc_channel) + 4'h1)
      else $error("converter channel did not step");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   pin_level_a: assert property (!power_good_pin_o && !int_pin_o
      && !status_or_role_pin_o)
      else $error("open drain pin driven high");
endmodule // csp_top_checker

bind csp_top csp_top_checker #(.INT_CYC(INT_CYC)) chk_u (.clk(clk), .resetn(resetn),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp(cmp), .charge_state(charge_state),
   .adc_req(adc_req), .adc_channel(adc_channel), .adc_done(adc_done),
   .power_good_pin_o(power_good_pin_o), .power_good_pin_oe(power_good_pin_oe),
   .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
   .status_or_role_pin_o(status_or_role_pin_o),
   .status_or_role_pin_oe(status_or_role_pin_oe), .switching_enable(switching_enable),
   .source_mode_active(source_mode_active),
   .reported_charge_state(reported_charge_state), .plus_line_level(plus_line_level),
   .minus_line_level(minus_line_level));

// ### tb/csp_conv_model.sv
// Converter model: answers each sample request after a short delay.
// Assumes the request is held until the answer pulse is seen.
`timescale 1ns/1ns
module csp_conv_model (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Sample port
   input wire logic adc_req,
   input wire logic [3:0] adc_channel,
   output logic adc_done,
   output logic [15:0] adc_data
);
   logic [1:0] wait_r;
   // Three cycles of conversion, then one done pulse; data scrambled otherwise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_r <= 2'h0;
         adc_done <= 1'b0;
         adc_data <= 16'h0000;
      end else if (adc_req && !adc_done && wait_r == 2'h2) begin
         wait_r <= 2'h0;
         adc_done <= 1'b1;
         adc_data <= {12'h010, adc_channel};
      end else begin
         wait_r <= (adc_req && !adc_done) ? wait_r + 2'h1 : 2'h0;
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
      end
   end
endmodule // csp_conv_model

// ### tb/test_charger_status_irq_protection_ctrl.sv
// Bench of the charger supervisory block: registers, pins, events, protections.
// Assumes the converter model beside the block and shortened timing parameters.
`timescale 1ns/1ns
module test_charger_status_irq_protection_ctrl;
   localparam int INT_CYC = 8;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   csp_pkg::csp_cmp_t cmp = '0;
   logic [2:0] charge_state = 3'h0;
   logic role_lvl = 1'b0;
   logic [7:0] reg_rdata;
   logic adc_req, adc_done, pg_o, pg_oe, int_o, int_oe, st_i, st_o, st_oe;
   logic sw_en, src_act, fet1, ibat_en, snap;
   logic [3:0] adc_ch;
   logic [15:0] adc_data;
   logic [2:0] rep_state, dp_lvl, dm_lvl;
   int bad_count = 0;
   int checks = 0;
   int wid;
   // Shared pin with pull-up: low while the block drives it
   assign st_i = st_oe ? 1'b0 : role_lvl;
   initial begin
      forever #25 clk = ~clk;
   end
   csp_top #(.INT_CYC(INT_CYC), .BLINK_CYC(4), .HIC_CYC(3)) dut_u (.clk(clk),
      .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp(cmp), .charge_state(charge_state),
      .adc_req(adc_req), .adc_channel(adc_ch), .adc_done(adc_done), .adc_data(adc_data),
      .power_good_pin_o(pg_o), .power_good_pin_oe(pg_oe), .int_pin_o(int_o),
      .int_pin_oe(int_oe), .status_or_role_pin_i(st_i), .status_or_role_pin_o(st_o),
      .status_or_role_pin_oe(st_oe), .switching_enable(sw_en), .source_mode_active(src_act),
      .input_one_fet_drive(fet1), .battery_current_output_enable(ibat_en),
      .reported_charge_state(rep_state), .plus_line_level(dp_lvl), .minus_line_level(dm_lvl));
   csp_conv_model conv_u (.clk(clk), .resetn(resetn), .adc_req(adc_req),
      .adc_channel(adc_ch), .adc_done(adc_done), .adc_data(adc_data));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // Waits for an interrupt pulse and measures its length
   task automatic wait_int(output int w);
      int n;
      n = 0;
      w = 0;
      while (int_oe !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      if (n == 300) begin
         bad_count++;
         $display("[FAIL] %0t no interrupt pulse", $time);
         give_verdict();
      end
      while (int_oe === 1'b1 && w < 300) begin
         cyc(1);
         w++;
      end
   endtask
   task automatic t_regs();
      rd(8'h10, 8'h20);
      rd(8'h11, 8'h20);
      rd(8'h28, 8'h00);
      rd(8'h2d, 8'h00);
      rd(8'h4e, 8'hff);
      rd(8'hff, 8'h00);
   endtask
   task automatic t_pg();
      @(posedge clk);
      cmp.bus_above_uvlo <= 1'b1;
      cmp.detect_done <= 1'b1;
      wait_int(wid);
      chk(pg_oe, 1'b1);
      @(posedge clk);
      cmp.die_hot <= 1'b1;
      cyc(2);
      chk(pg_oe, 1'b0);
      @(posedge clk);
      cmp.die_hot <= 1'b0;
      cmp.bc12_busy <= 1'b1;
      rd(8'h23, 8'h02);
      wr(8'h12, 8'h11);
      cyc(2);
      chk(dp_lvl, 3'h0);
      @(posedge clk);
      cmp.bc12_busy <= 1'b0;
      cyc(2);
      chk({dm_lvl, dp_lvl}, 6'h11);
   endtask
   task automatic t_stat();
      @(posedge clk);
      charge_state <= 3'h3;
      cyc(2);
      chk(st_oe, 1'b1);
      @(posedge clk);
      cmp.term_disable <= 1'b1;
      charge_state <= 3'h4;
      cyc(2);
      chk(st_oe, 1'b1);
      @(posedge clk);
      charge_state <= 3'h6;
      cyc(2);
      chk(st_oe, 1'b0);
      @(posedge clk);
      charge_state <= 3'h0;
      cmp.fault_stop <= 1'b1;
      cyc(2);
      snap = st_oe;
      cyc(4);
      chk(st_oe, !snap);
      chk(int_oe, 1'b0);
      wr(8'h10, 8'h21);
      @(posedge clk);
      charge_state <= 3'h3;
      cmp.fault_stop <= 1'b0;
      cyc(3);
      chk(st_oe, 1'b0);
      wr(8'h10, 8'h20);
   endtask
   task automatic t_int();
      @(posedge clk);
      cmp.bus_ovp <= 1'b1;
      wait_int(wid);
      chk(wid, INT_CYC);
      chk({sw_en, rep_state}, 4'h0);
      @(posedge clk);
      cmp.bus_ovp <= 1'b0;
      cyc(2);
      chk(rep_state, 3'h3);
      @(posedge clk);
      cmp.bus_ovp <= 1'b1;
      repeat (INT_CYC + 4) begin
         cyc(1);
         chk(int_oe, 1'b0);
      end
      @(posedge clk);
      cmp.bus_ovp <= 1'b0;
      rd(8'h22, 8'h01);
      rd(8'h22, 8'h00);
   endtask
   task automatic t_adc();
      wr(8'h11, 8'h2c);
      wait_int(wid);
      rd(8'h23, 8'h01);
      rd(8'h34, 8'h02);
      rd(8'h35, 8'h01);
      rd(8'h30, 8'h00);
      rd(8'h31, 8'h01);
      rd(8'h11, 8'h28);
   endtask
   task automatic t_prot();
      @(posedge clk);
      cmp.in1_ovp <= 1'b1;
      wait_int(wid);
      chk(fet1, 1'b0);
      rd(8'h13, 8'h09);
      @(posedge clk);
      cmp.in1_ovp <= 1'b0;
      rd(8'h22, 8'h04);
      @(posedge clk);
      cmp.ibus_oc <= 1'b1;
      wait_int(wid);
      rd(8'h10, 8'h30);
      rd(8'h11, 8'h18);
      chk(sw_en, 1'b0);
      @(posedge clk);
      cmp.ibus_oc <= 1'b0;
      wr(8'h10, 8'h20);
      cyc(2);
      chk(sw_en, 1'b1);
      @(posedge clk);
      cmp.sys_ovp <= 1'b1;
      wait_int(wid);
      chk(sw_en, 1'b0);
      @(posedge clk);
      cmp.sys_ovp <= 1'b0;
      cyc(2);
      chk(sw_en, 1'b1);
   endtask
   // Source mode: role swap, signed results, source faults, seamless, system hiccup
   task automatic t_src();
      @(posedge clk);
      role_lvl <= 1'b1;
      cmp.bus_below_mivr <= 1'b1;
      wr(8'h10, 8'h2f);
      wait_int(wid);
      chk(src_act, 1'b1);
      rd(8'h23, 8'h04);
      wr(8'h11, 8'h4c);
      wait_int(wid);
      chk(ibat_en, 1'b1);
      rd(8'h31, 8'hff);
      rd(8'h33, 8'hfe);
      rd(8'h35, 8'h01);
      @(posedge clk);
      cmp.src_ovp <= 1'b1;
      wait_int(wid);
      chk(sw_en, 1'b0);
      @(posedge clk);
      cmp.src_ovp <= 1'b0;
      cyc(2);
      chk(sw_en, 1'b1);
      @(posedge clk);
      cmp.src_uv <= 1'b1;
      cyc(2);
      chk({sw_en, src_act}, 2'h1);
      wait_int(wid);
      chk(src_act, 1'b0);
      rd(8'h10, 8'h2b);
      @(posedge clk);
      cmp.src_uv <= 1'b0;
      cmp.adapter_present <= 1'b1;
      wr(8'h10, 8'h20);
      wr(8'h11, 8'h01);
      cyc(2);
      chk(src_act, 1'b0);
      @(posedge clk);
      cmp.adapter_present <= 1'b0;
      wait_int(wid);
      chk(src_act, 1'b1);
      rd(8'h10, 8'h24);
      rd(8'h11, 8'h00);
      wr(8'h10, 8'h20);
      @(posedge clk);
      cmp.sys_uv <= 1'b1;
      wait_int(wid);
      cyc(25);
      rd(8'h10, 8'h30);
      chk(sw_en, 1'b0);
      @(posedge clk);
      cmp.sys_uv <= 1'b0;
      wr(8'h10, 8'h20);
      cyc(2);
      chk(sw_en, 1'b1);
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_pg();
      t_stat();
      t_int();
      t_adc();
      t_prot();
      t_src();
      give_verdict();
   end
endmodule // test_charger_status_irq_protection_ctrl
